/* File: hdl/misc_cfg_pkg.sv */
// Constants shared by the system configuration register bank
`default_nettype none
package misc_cfg_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PORT_DATA_UPPER = 8'h10;
  localparam logic [7:0] OFS_RX_FIFO_STATUS  = 8'h20;
  localparam logic [7:0] OFS_VIDEO_DAC_CFG   = 8'h24;
  localparam logic [7:0] OFS_VIDEO_PAD_CFG   = 8'h28;
  localparam logic [7:0] OFS_EXT_RESET_CFG   = 8'h2c;
  localparam logic [7:0] OFS_AUDIO_CFG       = 8'h30;
  localparam logic [7:0] OFS_PORT_STATUS     = 8'h3c;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_RX_FIFO_FLUSH   = 31;
  localparam int BIT_EXT_HOLD        = 4;
  localparam int BIT_EXT_DUR_LO      = 2;
  localparam int BIT_EXT_PULSE       = 1;
  localparam int BIT_EXT_POL         = 0;
  localparam int BIT_FAST_COUNT      = 31;
  localparam int BIT_BITCLK_SEL      = 4;
  localparam int BIT_MEASURE_EN      = 1;
  localparam int BIT_AUDIO_EN        = 0;
  localparam int BIT_PORT_READY      = 0;
  localparam logic [7:0] VDAC_MASK   = 8'hf7;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_RX_FREE = 16'h4800;
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 8;
  localparam int T_PULSE0_NS  = 50_000;
  localparam int T_PULSE1_NS  = 1_000_000;
  localparam int T_PULSE2_NS  = 32_000_000;
  localparam int T_PULSE3_NS  = 128_000_000;
  localparam int T_WIN_NS     = 1_000_000;
  localparam int T_FAST_NS    = 1_000;
  localparam int CYC_FAST     = (T_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_WIN      = T_WIN_NS / CLK_NS;
  localparam int CYC_PULSE0   = (T_PULSE0_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_PULSE1   = (T_PULSE1_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_PULSE2   = (T_PULSE2_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_PULSE3   = (T_PULSE3_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 24;
  localparam int WIN_W        = 17;
  localparam int NCH          = 4;
  typedef logic [NCH-1:0][15:0] counts_t;
endpackage
`default_nettype wire

/* File: hdl/toggle_meter_if.sv */
// Carrier between the register bank and the toggle-rate meter
`default_nettype none
interface toggle_meter_if;
  import misc_cfg_pkg::*;
  logic                en;
  logic                fast;
  logic [NCH-1:0]      lvl;
  counts_t             cnt;
  logic                valid;
  modport ctl   (output en, output fast, output lvl,
                 input cnt, input valid);
  modport meter (input en, input fast, input lvl,
                 output cnt, output valid);
endinterface
`default_nettype wire

/* File: hdl/toggle_meter.sv */
// Rising-edge counter per audio pin over a fixed window
`default_nettype none
module toggle_meter #(
  parameter int P_WIN_CYC = misc_cfg_pkg::CYC_WIN
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Bank side
  toggle_meter_if.meter   m
);
  import misc_cfg_pkg::*;

  typedef struct packed {
    logic [WIN_W-1:0] win;
    logic [NCH-1:0]   prev;
    counts_t          acc;
    counts_t          res;
    logic             valid;
  } state_s;

  state_s r_ff;
  state_s nxt_r;
  logic [WIN_W-1:0] last;

  always_comb begin
    nxt_r       = r_ff;
    nxt_r.valid = 1'b0;
    nxt_r.prev  = m.lvl;
    // Test mode shortens the window so a bench sees results fast
    last = m.fast ? WIN_W'(CYC_FAST - 1) : WIN_W'(P_WIN_CYC - 1);
    if (!m.en) begin
      nxt_r.win = '0;
      nxt_r.acc = '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (m.lvl[i] && !r_ff.prev[i] && r_ff.acc[i] != 16'hffff)
          nxt_r.acc[i] = r_ff.acc[i] + 16'h0001;
      end
      if (r_ff.win >= last) begin
        nxt_r.win   = '0;
        nxt_r.res   = nxt_r.acc;
        nxt_r.acc   = '0;
        nxt_r.valid = 1'b1;
      end else begin
        nxt_r.win = r_ff.win + WIN_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign m.cnt   = r_ff.res;
  assign m.valid = r_ff.valid;
endmodule
`default_nettype wire

/* File: hdl/misc_cfg_regs.sv */
// System configuration and status register bank on APB
//
// The APB interface to the registers was decided locally.
`default_nettype none
module misc_cfg_regs #(
  parameter int P_PULSE0_CYC = misc_cfg_pkg::CYC_PULSE0,
  parameter int P_PULSE1_CYC = misc_cfg_pkg::CYC_PULSE1,
  parameter int P_PULSE2_CYC = misc_cfg_pkg::CYC_PULSE2,
  parameter int P_PULSE3_CYC = misc_cfg_pkg::CYC_PULSE3,
  parameter int P_WIN_CYC    = misc_cfg_pkg::CYC_WIN
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Indirect port
  input  wire logic        i_port_busy,
  input  wire logic        i_port_rd_done,
  input  wire logic [31:0] i_port_rd_upper,
  output logic [31:0]      o_port_wdata_upper,
  // Receive FIFO
  input  wire logic [15:0] i_rx_free_bytes,
  output logic             o_rx_fifo_flush,
  // Video DAC and pads
  output logic [2:0]       o_dac_chan_power,
  output logic             o_ext_ref_current_en,
  output logic             o_full_scale_34ma_en,
  output logic             o_bias_test_ctl_one,
  output logic             o_bias_test_ctl_zero,
  output logic             o_analog_sync_pad_en,
  output logic             o_parallel_video_pad_en,
  // External reset
  input  wire logic        i_rst_protect,
  input  wire logic        i_eeprom_load,
  input  wire logic        i_eeprom_present,
  input  wire logic        i_eeprom_ext_pol,
  input  wire logic        i_usb_reset,
  input  wire logic        i_lite_reset,
  output logic             o_ext_reset_pin,
  // Serial audio pins, asynchronous
  input  wire logic        i_ws_pin,
  input  wire logic        i_bitclk_alt_pin_zero,
  input  wire logic        i_bitclk_alt_pin_one,
  input  wire logic        i_mclk_pin,
  input  wire logic        i_data_pin,
  // Serial audio control and results
  output logic             o_serial_audio_en,
  output logic             o_bitclk_pin_select,
  output logic [15:0]      o_ws_toggles,
  output logic [15:0]      o_bitclk_toggles,
  output logic [15:0]      o_mclk_toggles,
  output logic [15:0]      o_data_toggles,
  output logic             o_toggles_valid
);
  import misc_cfg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic [31:0]       data_upper;
    logic              flush;
    logic [15:0]       free;
    logic [7:0]        vdac;
    logic [1:0]        pad;
    logic              hold;
    logic [1:0]        dur;
    logic              pulse;
    logic              pol;
    logic              img_pol;
    logic [CNT_W-1:0]  rst_cnt;
    logic              pin;
    logic              fast;
    logic              clk_sel;
    logic              meas_en;
    logic              audio_en;
    logic [4:0]        sync1;
    logic [4:0]        sync2;
    logic              ready;
  } state_s;

  state_s r_ff;
  state_s nxt_r;

  logic [31:0]      rd_data;
  logic             hit;
  logic             wr_en;
  logic [CNT_W-1:0] dur_cyc;

  toggle_meter_if tm ();

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r         = r_ff;
    nxt_r.pready  = 1'b0;
    nxt_r.pslverr = 1'b0;
    nxt_r.flush   = 1'b0;
    rd_data       = RST_ZERO;
    hit           = 1'b1;
    dur_cyc       = CNT_W'(P_PULSE0_CYC);

    // Read mux; unlisted bits stay zero
    case (i_paddr)
      OFS_PORT_DATA_UPPER: rd_data = r_ff.data_upper;
      OFS_RX_FIFO_STATUS:  rd_data[15:0] = r_ff.free;
      OFS_VIDEO_DAC_CFG:   rd_data[7:0] = r_ff.vdac;
      OFS_VIDEO_PAD_CFG:   rd_data[1:0] = r_ff.pad;
      OFS_EXT_RESET_CFG: begin
        rd_data[BIT_EXT_HOLD]                    = r_ff.hold;
        rd_data[BIT_EXT_DUR_LO+1:BIT_EXT_DUR_LO] = r_ff.dur;
        rd_data[BIT_EXT_PULSE]                   = r_ff.pulse;
        rd_data[BIT_EXT_POL]                     = r_ff.pol;
      end
      OFS_AUDIO_CFG: begin
        rd_data[BIT_FAST_COUNT] = r_ff.fast;
        rd_data[BIT_BITCLK_SEL] = r_ff.clk_sel;
        rd_data[BIT_MEASURE_EN] = r_ff.meas_en;
        rd_data[BIT_AUDIO_EN]   = r_ff.audio_en;
      end
      OFS_PORT_STATUS: rd_data[BIT_PORT_READY] = r_ff.ready;
      default: hit = 1'b0;
    endcase

    // One wait state keeps every APB output straight from a flop
    if (i_psel && i_penable && !r_ff.pready) begin
      nxt_r.pready  = 1'b1;
      nxt_r.prdata  = rd_data;
      nxt_r.pslverr = !hit;
    end
    wr_en = i_psel && i_penable && r_ff.pready && i_pwrite && hit;

    if (wr_en) begin
      case (i_paddr)
        OFS_PORT_DATA_UPPER: nxt_r.data_upper = i_pwdata;
        OFS_RX_FIFO_STATUS:
          nxt_r.flush = i_pwdata[BIT_RX_FIFO_FLUSH];
        OFS_VIDEO_DAC_CFG:
          nxt_r.vdac = i_pwdata[7:0] & VDAC_MASK;
        OFS_VIDEO_PAD_CFG: nxt_r.pad = i_pwdata[1:0];
        OFS_EXT_RESET_CFG: begin
          nxt_r.hold = i_pwdata[BIT_EXT_HOLD];
          nxt_r.dur  = i_pwdata[BIT_EXT_DUR_LO+1:BIT_EXT_DUR_LO];
          // A second start while a pulse runs does not retrigger it
          if (i_pwdata[BIT_EXT_PULSE] && !r_ff.pulse)
            nxt_r.pulse = 1'b1;
          if (!i_rst_protect)
            nxt_r.pol = i_pwdata[BIT_EXT_POL];
        end
        OFS_AUDIO_CFG: begin
          nxt_r.fast     = i_pwdata[BIT_FAST_COUNT];
          nxt_r.clk_sel  = i_pwdata[BIT_BITCLK_SEL];
          nxt_r.meas_en  = i_pwdata[BIT_MEASURE_EN];
          nxt_r.audio_en = i_pwdata[BIT_AUDIO_EN];
        end
        default: nxt_r.hold = r_ff.hold;
      endcase
    end

    // Returned read data wins over a software write in the same cycle
    if (i_port_rd_done)
      nxt_r.data_upper = i_port_rd_upper;
    nxt_r.ready = !i_port_busy;
    nxt_r.free  = {i_rx_free_bytes[15:3], 3'b000};

    // Polarity image from the configuration store
    if (i_eeprom_load) begin
      nxt_r.img_pol = i_eeprom_present && i_eeprom_ext_pol;
      nxt_r.pol     = i_eeprom_present && i_eeprom_ext_pol;
    end else if (i_usb_reset || i_lite_reset) begin
      nxt_r.pol = r_ff.img_pol;
    end

    // ----------------------------------------------------------------
    // External reset pulse
    // ----------------------------------------------------------------
    // A period written together with the start bit governs that pulse
    case (nxt_r.dur)
      2'b00:   dur_cyc = CNT_W'(P_PULSE0_CYC);
      2'b01:   dur_cyc = CNT_W'(P_PULSE1_CYC);
      2'b10:   dur_cyc = CNT_W'(P_PULSE2_CYC);
      2'b11:   dur_cyc = CNT_W'(P_PULSE3_CYC);
      default: dur_cyc = CNT_W'(P_PULSE0_CYC);
    endcase
    if (!r_ff.pulse) begin
      nxt_r.rst_cnt = dur_cyc - CNT_W'(1);
    end else if (r_ff.rst_cnt == '0) begin
      nxt_r.pulse = 1'b0;
    end else begin
      nxt_r.rst_cnt = r_ff.rst_cnt - CNT_W'(1);
    end
    // Pin level: asserted when hold or pulse, then polarity applied
    nxt_r.pin = !((nxt_r.hold || nxt_r.pulse) ^ nxt_r.pol);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    nxt_r.sync1 = {i_data_pin, i_mclk_pin, i_bitclk_alt_pin_one,
                   i_bitclk_alt_pin_zero, i_ws_pin};
    nxt_r.sync2 = r_ff.sync1;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r_ff      <= '0;
      r_ff.free <= RST_RX_FREE;
      r_ff.pin  <= 1'b1;
      r_ff.ready <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // Toggle-rate meter
  // ----------------------------------------------------------------
  assign tm.en   = r_ff.audio_en && r_ff.meas_en;
  assign tm.fast = r_ff.fast;
  assign tm.lvl  = {r_ff.sync2[4], r_ff.sync2[3],
                    r_ff.clk_sel ? r_ff.sync2[2] : r_ff.sync2[1],
                    r_ff.sync2[0]};

  toggle_meter #(
    .P_WIN_CYC (P_WIN_CYC)
  ) u_meter (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .m        (tm.meter)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_prdata                = r_ff.prdata;
  assign o_pready                = r_ff.pready;
  assign o_pslverr               = r_ff.pslverr;
  assign o_port_wdata_upper      = r_ff.data_upper;
  assign o_rx_fifo_flush         = r_ff.flush;
  assign o_dac_chan_power        = r_ff.vdac[2:0];
  assign o_ext_ref_current_en    = r_ff.vdac[7];
  assign o_full_scale_34ma_en    = r_ff.vdac[6];
  assign o_bias_test_ctl_one     = r_ff.vdac[5];
  assign o_bias_test_ctl_zero    = r_ff.vdac[4];
  assign o_analog_sync_pad_en    = r_ff.pad[1];
  assign o_parallel_video_pad_en = r_ff.pad[0];
  assign o_ext_reset_pin         = r_ff.pin;
  assign o_serial_audio_en       = r_ff.audio_en;
  assign o_bitclk_pin_select     = r_ff.clk_sel;
  assign o_ws_toggles            = tm.cnt[0];
  assign o_bitclk_toggles        = tm.cnt[1];
  assign o_mclk_toggles          = tm.cnt[2];
  assign o_data_toggles          = tm.cnt[3];
  assign o_toggles_valid         = tm.valid;
endmodule
`default_nettype wire

/* File: tb/misc_cfg_regs_asserts.sv */
// Port-level assertions for the configuration register bank
`default_nettype none
module misc_cfg_regs_asserts (
  // Clock, reset and APB
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Block side
  input wire logic        i_port_rd_done,
  input wire logic [31:0] i_port_rd_upper,
  input wire logic [31:0] o_port_wdata_upper,
  input wire logic        o_rx_fifo_flush,
  input wire logic [2:0]  o_dac_chan_power,
  input wire logic        o_ext_ref_current_en,
  input wire logic        o_full_scale_34ma_en,
  input wire logic        o_bias_test_ctl_one,
  input wire logic        o_bias_test_ctl_zero,
  input wire logic        o_analog_sync_pad_en,
  input wire logic        o_parallel_video_pad_en,
  input wire logic        o_serial_audio_en,
  input wire logic        o_bitclk_pin_select,
  input wire logic        o_toggles_valid
);
  import misc_cfg_pkg::*;
  logic        wr_edge;
  logic        hit;
  logic [31:0] wd_q;
  // ----
  // Helpers
  // ----
  assign hit = i_paddr inside {OFS_PORT_DATA_UPPER, OFS_RX_FIFO_STATUS,
    OFS_VIDEO_DAC_CFG, OFS_VIDEO_PAD_CFG, OFS_EXT_RESET_CFG,
    OFS_AUDIO_CFG, OFS_PORT_STATUS};
  assign wr_edge = i_psel & i_penable & i_pwrite & o_pready;
  // Write data of the last edge, so field checks need no $past of a slice
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wd_q <= 32'h0000_0000;
    end else begin
      wd_q <= i_pwdata;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // ----
  // Properties
  // ----
  property p_upper_wr;
    wr_edge && i_paddr == OFS_PORT_DATA_UPPER && !i_port_rd_done
      |=> o_port_wdata_upper == wd_q;
  endproperty
  a_upper_wr: assert property (p_upper_wr)
    else $error("upper data not written");
  property p_upper_ld;
    i_port_rd_done |=> o_port_wdata_upper == $past(i_port_rd_upper);
  endproperty
  a_upper_ld: assert property (p_upper_ld)
    else $error("upper data not loaded from port");
  property p_flush;
    wr_edge && i_paddr == OFS_RX_FIFO_STATUS && i_pwdata[BIT_RX_FIFO_FLUSH]
      |=> o_rx_fifo_flush ##1 !o_rx_fifo_flush;
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush pulse wrong");
  property p_dac_lo;
    wr_edge && i_paddr == OFS_VIDEO_DAC_CFG |=> o_dac_chan_power == wd_q[2:0];
  endproperty
  a_dac_lo: assert property (p_dac_lo)
    else $error("dac channel power wrong");
  property p_dac_hi;
    wr_edge && i_paddr == OFS_VIDEO_DAC_CFG |=> {o_ext_ref_current_en,
      o_full_scale_34ma_en, o_bias_test_ctl_one, o_bias_test_ctl_zero}
      == wd_q[7:4];
  endproperty
  a_dac_hi: assert property (p_dac_hi)
    else $error("dac controls wrong");
  property p_pads;
    wr_edge && i_paddr == OFS_VIDEO_PAD_CFG
      |=> {o_analog_sync_pad_en, o_parallel_video_pad_en} == wd_q[1:0];
  endproperty
  a_pads: assert property (p_pads)
    else $error("pad enables wrong");
  property p_audio;
    wr_edge && i_paddr == OFS_AUDIO_CFG |=> o_serial_audio_en ==
      wd_q[BIT_AUDIO_EN] && o_bitclk_pin_select == wd_q[BIT_BITCLK_SEL];
  endproperty
  a_audio: assert property (p_audio)
    else $error("audio controls wrong");
  property p_valid;
    o_toggles_valid |-> $past(o_serial_audio_en);
  endproperty
  a_valid: assert property (p_valid)
    else $error("result without audio enable");
  property p_err;
    o_pready |-> o_pslverr == !hit;
  endproperty
  a_err: assert property (p_err)
    else $error("error response wrong");
endmodule
bind misc_cfg_regs misc_cfg_regs_asserts chk_u (.*);
`default_nettype wire

/* File: tb/misc_cfg_regs_tb_top.sv */
// Self-checking bench for the configuration register bank
`default_nettype none
module misc_cfg_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import misc_cfg_pkg::*;
  // ----
  // Signals
  // ----
  // Short pulse and window lengths keep the run brief
  localparam int DUR [4] = '{10, 20, 40, 60};
  localparam int WIN     = 192;
  logic        i_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, i_port_rd_upper = 32'h0;
  logic [15:0] i_rx_free_bytes = 16'h4800;
  logic        i_port_busy = 1'b0, i_port_rd_done = 1'b0;
  logic        i_rst_protect = 1'b0, i_eeprom_load = 1'b0;
  logic        i_eeprom_present = 1'b0, i_eeprom_ext_pol = 1'b0;
  logic        i_usb_reset = 1'b0, i_lite_reset = 1'b0;
  logic        i_data_pin = 1'b0;
  logic        i_bitclk_alt_pin_zero = 1'b0;
  logic [7:0]  tick = 8'h00;
  wire         i_ws_pin = tick[3];
  wire         i_bitclk_alt_pin_one = tick[2];
  wire         i_mclk_pin = tick[1];
  logic [31:0] o_prdata, o_port_wdata_upper;
  logic [15:0] o_ws_toggles, o_bitclk_toggles, o_mclk_toggles, o_data_toggles;
  logic [2:0]  o_dac_chan_power;
  logic        o_pready, o_pslverr, o_rx_fifo_flush, o_ext_ref_current_en;
  logic        o_full_scale_34ma_en, o_bias_test_ctl_one, o_bias_test_ctl_zero;
  logic        o_analog_sync_pad_en, o_parallel_video_pad_en, o_ext_reset_pin;
  logic        o_serial_audio_en, o_bitclk_pin_select, o_toggles_valid;
  int          n_fail = 0;
  int          compares = 0;
  misc_cfg_regs #(
    .P_PULSE0_CYC (DUR[0]),
    .P_PULSE1_CYC (DUR[1]),
    .P_PULSE2_CYC (DUR[2]),
    .P_PULSE3_CYC (DUR[3]),
    .P_WIN_CYC    (WIN)
  ) dut_u (.*);
  always #4 i_clk = ~i_clk;
  // Rising edges every 4, 8 and 16 cycles give exact counts per window
  always @(posedge i_clk) tick <= tick + 8'h01;
  // ----
  // Tasks
  // ----
  task automatic stop_test;
    $display("Compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge i_clk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // Ready, read data and error are taken at the completing edge itself
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (o_pready === 1'b1) break;
    end
    if (k == 20) begin
      n_fail++;
      stop_test();
    end
    r = o_prdata;
    chk("pslverr", {31'h0, !(a inside {8'h10, 8'h20, 8'h24, 8'h28, 8'h2c,
        8'h30, 8'h3c})}, 32'(o_pslverr));
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(nm, x, r);
  endtask
  task automatic wait_valid(input int lim, input bit quiet, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge i_clk);
      #1;
      if (o_toggles_valid === 1'b1) break;
    end
    if (n == lim && !quiet) begin
      n_fail++;
      stop_test();
    end
  endtask
  // The first window after a change may be partial, so it is skipped
  task automatic period(output int n);
    wait_valid(400, 1'b0, n);
    wait_valid(400, 1'b0, n);
    n++;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rdc("upper", OFS_PORT_DATA_UPPER, RST_ZERO);
    rdc("free", OFS_RX_FIFO_STATUS, {16'h0, RST_RX_FREE});
    rdc("dac", OFS_VIDEO_DAC_CFG, RST_ZERO);
    rdc("pads", OFS_VIDEO_PAD_CFG, RST_ZERO);
    rdc("extrst", OFS_EXT_RESET_CFG, RST_ZERO);
    rdc("audio", OFS_AUDIO_CFG, RST_ZERO);
    rdc("ready", OFS_PORT_STATUS, 32'h1);
    chk("pin", 32'h1, 32'(o_ext_reset_pin));
  endtask
  task automatic t_fields;
    logic [31:0] v;
    i_rx_free_bytes <= 16'h123f;
    wr(OFS_VIDEO_DAC_CFG, 32'hffff_ffff);
    wr(OFS_VIDEO_PAD_CFG, 32'h0000_0001);
    rdc("dac", OFS_VIDEO_DAC_CFG, 32'h0000_00f7);
    rdc("pads", OFS_VIDEO_PAD_CFG, 32'h0000_0001);
    v = 32'({o_ext_ref_current_en, o_full_scale_34ma_en,
             o_bias_test_ctl_one, o_bias_test_ctl_zero, o_dac_chan_power});
    chk("dacout", 32'h0000_007f, v);
    v = 32'({o_analog_sync_pad_en, o_parallel_video_pad_en});
    chk("padout", 32'h0000_0001, v);
    rdc("unmapped", 8'h44, 32'h0);
    wr(OFS_RX_FIFO_STATUS, 32'h8000_ffff);
    #1;
    chk("flush", 32'h1, 32'(o_rx_fifo_flush));
    @(posedge i_clk);
    #1;
    chk("flush1", 32'h0, 32'(o_rx_fifo_flush));
    rdc("free", OFS_RX_FIFO_STATUS, 32'h0000_1238);
  endtask
  task automatic t_upper;
    wr(OFS_PORT_DATA_UPPER, 32'ha5a5_5a5a);
    i_port_busy <= 1'b1;
    #1;
    chk("wdata", 32'ha5a5_5a5a, o_port_wdata_upper);
    rdc("busy", OFS_PORT_STATUS, 32'h0);
    i_port_rd_upper <= 32'h3c3c_c3c3;
    i_port_rd_done  <= 1'b1;
    @(posedge i_clk);
    i_port_rd_done <= 1'b0;
    i_port_busy    <= 1'b0;
    rdc("ready", OFS_PORT_STATUS, 32'h1);
    rdc("rdata", OFS_PORT_DATA_UPPER, 32'h3c3c_c3c3);
  endtask
  task automatic t_ext;
    int n;
    wr(OFS_EXT_RESET_CFG, 32'h0000_0010);
    #1;
    chk("hold", 32'h0, 32'(o_ext_reset_pin));
    wr(OFS_EXT_RESET_CFG, 32'h0000_0000);
    #1;
    chk("release", 32'h1, 32'(o_ext_reset_pin));
    for (int d = 0; d < 4; d++) begin
      wr(OFS_EXT_RESET_CFG, 32'(d * 4 + 2));
      n = 0;
      for (int k = 0; k < 200; k++) begin
        #1;
        if (o_ext_reset_pin === 1'b1) break;
        n++;
        @(posedge i_clk);
      end
      chk("duration", 32'(DUR[d]), 32'(n));
      rdc("selfclr", OFS_EXT_RESET_CFG, 32'(d * 4));
    end
  endtask
  task automatic t_pol;
    i_rst_protect <= 1'b1;
    wr(OFS_EXT_RESET_CFG, 32'h0000_0001);
    rdc("guard", OFS_EXT_RESET_CFG, 32'h0);
    i_rst_protect <= 1'b0;
    wr(OFS_EXT_RESET_CFG, 32'h0000_0001);
    #1;
    chk("highpol", 32'h0, 32'(o_ext_reset_pin));
    @(posedge i_clk);
    i_lite_reset <= 1'b1;
    @(posedge i_clk);
    i_lite_reset <= 1'b0;
    rdc("lite", OFS_EXT_RESET_CFG, 32'h0);
    i_eeprom_present <= 1'b1;
    i_eeprom_ext_pol <= 1'b1;
    i_eeprom_load    <= 1'b1;
    @(posedge i_clk);
    i_eeprom_load <= 1'b0;
    rdc("load", OFS_EXT_RESET_CFG, 32'h1);
    wr(OFS_EXT_RESET_CFG, 32'h0000_0000);
    i_usb_reset <= 1'b1;
    @(posedge i_clk);
    i_usb_reset <= 1'b0;
    rdc("usb", OFS_EXT_RESET_CFG, 32'h1);
  endtask
  task automatic t_audio;
    int n;
    wr(OFS_AUDIO_CFG, 32'h0000_0013);
    #1;
    chk("audio", 32'h3, 32'({o_bitclk_pin_select, o_serial_audio_en}));
    period(n);
    chk("window", WIN, n);
    chk("bclk", 32'(WIN / 8), 32'(o_bitclk_toggles));
    chk("ws", 32'(WIN / 16), 32'(o_ws_toggles));
    chk("mclk", 32'(WIN / 4), 32'(o_mclk_toggles));
    chk("data", 32'h0, 32'(o_data_toggles));
    wr(OFS_AUDIO_CFG, 32'h0000_0003);
    period(n);
    chk("bclk0", 32'h0, 32'(o_bitclk_toggles));
    wr(OFS_AUDIO_CFG, 32'h8000_0013);
    period(n);
    chk("fast", CYC_FAST, n);
    wr(OFS_AUDIO_CFG, 32'h0000_0012);
    wait_valid(2 * WIN, 1'b1, n);
    chk("nomeas", 2 * WIN, n);
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_reset();
    t_fields();
    t_upper();
    t_ext();
    t_pol();
    t_audio();
    stop_test();
  end
endmodule
`default_nettype wire
